// ---- verilog/fault_trip_supervisor.sv ----
// Purpose: Watches motor measurements and checks, latches trips, stops motor.
// Assumes: Measurements and checks come from logic on clk; digital inputs
//          are pins. Reset is the power-on reset of the drive.
// Notes: Registers over AXI4-Lite; see package for offsets.
`timescale 1ns/1ps
`default_nettype none
module fault_trip_supervisor
   import fault_sup_pkg::*;
#(
   parameter bit HIGH_VOLT = 1'b0,
   parameter bit BIG_UNIT = 1'b0,
   parameter int OL_HOLD = 125000
) (
   input wire logic clk,
   input wire logic resetn,
   input wire meas_t meas,
   input wire check_t checks,
   input wire logic first_digital_input,
   input wire logic second_digital_input,
   output logic trip_out,
   output logic motor_enable,
   output logic run_source,
   output code_t display_code,
   output logic display_flash,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   if (OL_HOLD < 1 || OL_HOLD > (1 << CNT_W)) begin : g_chk
      $error("OL_HOLD out of range");
   end

   localparam logic [CNT_W-1:0] OL_LIM = CNT_W'(OL_HOLD - 1);
   localparam logic [V_W-1:0] UV_LIM = HIGH_VOLT ? UV_LIM_200 : UV_LIM_100;
   localparam logic [V_W-1:0] OV_LIM = HIGH_VOLT ? OV_LIM_200 : OV_LIM_100;
   localparam logic [7:0] OLW_LIM = BIG_UNIT ? OLW_BIG : OLW_SMALL;
   localparam logic [7:0] OLT_LIM = BIG_UNIT ? OLT_BIG : OLT_SMALL;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      addr_ok = (a == ADDR_CTRL) || (a == ADDR_STATUS) ||
                (a == ADDR_CAUSE) || (a == ADDR_LATCH);
   endfunction : addr_ok

   // Lowest latch index wins so the first listed fault is reported
   function automatic code_t first_code(input logic [NFLT-1:0] l);
      first_code = no_trip_code;
      for (int i = NFLT - 1; i >= 0; i--) begin
         if (l[i]) begin
            first_code = code_t'(4'(i + 1));
         end
      end
   endfunction : first_code

   state_t st_ff, nxt_st;
   logic [NFLT-1:0] det;
   logic uv_low, ol_over, rst_cond, rst_edge, clear, wr_fire, cau_evt;
   logic ar_fire;
   logic [3:0] wr_ctrl;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      // Pin inputs: a change counts once stages two and three agree
      nxt_st.s1 = {second_digital_input, first_digital_input};
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      nxt_st.filt = (st_ff.s2 & st_ff.s3) |
                    (st_ff.filt & (st_ff.s2 ^ st_ff.s3));

      // Register writes
      wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
      wr_ctrl = st_ff.ctrl;
      if (wr_fire && st_ff.awaddr == ADDR_CTRL && st_ff.wstrb0) begin
         wr_ctrl = st_ff.wdata;
      end
      cau_evt = wr_ctrl[CTRL_RUN_SRC] != st_ff.ctrl[CTRL_RUN_SRC];
      nxt_st.ctrl = wr_ctrl;

      // Fault detection runs regardless of keypad presence
      uv_low = meas.dc_bus_v < UV_LIM;
      ol_over = meas.load_pct > OLT_LIM;
      nxt_st.ol_cnt = '0;
      if (ol_over) begin
         nxt_st.ol_cnt = (st_ff.ol_cnt == OL_LIM) ? OL_LIM
                         : st_ff.ol_cnt + 1'b1;
      end
      det = '0;
      det[F_UV] = uv_low && st_ff.ctrl[CTRL_UV_TRIP];
      det[F_OL] = ol_over && st_ff.ol_cnt == OL_LIM;
      det[F_OC] = checks.overcurrent;
      det[F_OV] = meas.dc_bus_v > OV_LIM;
      det[F_UPR] = checks.user_param_bad;
      det[F_SPR] = checks.sys_param_bad;
      det[F_SYS] = checks.cpu_fault;
      det[F_SEN] = checks.sensor_fault;
      det[F_OS] = meas.speed_rpm > SPEED_LIM;
      det[F_OH] = meas.temp_c > TEMP_LIM;
      det[F_CAU] = cau_evt;
      nxt_st.warn = meas.load_pct > OLW_LIM;

      // Trip reset: direction modes need both inputs, reset modes the second
      rst_cond = st_ff.ctrl[CTRL_MODE_LSB+1] ? st_ff.filt[1]
                 : (st_ff.filt[0] && st_ff.filt[1]);
      nxt_st.rst_prev = rst_cond;
      rst_edge = rst_cond && !st_ff.rst_prev;
      clear = rst_edge && st_ff.mode == mode_trip &&
              (st_ff.latch & HARD_MASK) == '0;
      // A fault seen in the clearing cycle stays latched
      nxt_st.latch = (clear ? '0 : st_ff.latch) | det;
      if (clear) begin
         nxt_st.run_src_act = st_ff.ctrl[CTRL_RUN_SRC];
      end
      nxt_st.cause = first_code(nxt_st.latch);

      case (st_ff.mode)
         mode_run, mode_pause, mode_trip: begin
            if (nxt_st.latch != '0) begin
               nxt_st.mode = mode_trip;
            end else if (uv_low) begin
               nxt_st.mode = mode_pause;
            end else begin
               nxt_st.mode = mode_run;
            end
         end
         default: begin
            nxt_st.mode = mode_trip;
         end
      endcase

      // Keypad shows codes and flashes only while attached
      nxt_st.disp = no_trip_code;
      if (checks.keypad_present) begin
         if (nxt_st.mode == mode_trip) begin
            nxt_st.disp = nxt_st.cause;
         end else if (nxt_st.mode == mode_pause) begin
            nxt_st.disp = undervoltage_pause_code;
         end
      end
      nxt_st.flash = checks.keypad_present && nxt_st.warn;

      // Write channel: address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = s_axi_wdata[3:0];
         nxt_st.wstrb0 = s_axi_wstrb[0];
      end
      if (wr_fire) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = addr_ok(st_ff.awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end

      // Read channel
      ar_fire = s_axi_arvalid && !st_ff.rvalid;
      if (ar_fire) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            ADDR_CTRL: begin
               nxt_st.rdata = {28'h0000000, st_ff.ctrl};
            end
            ADDR_STATUS: begin
               nxt_st.rdata = {27'h0000000, st_ff.run_src_act,
                               checks.keypad_present, st_ff.warn,
                               st_ff.mode};
            end
            ADDR_CAUSE: begin
               nxt_st.rdata = {28'h0000000, st_ff.cause};
            end
            ADDR_LATCH: begin
               nxt_st.rdata = {21'h000000, st_ff.latch};
            end
            default: begin
               nxt_st.rdata = 32'h00000000;
            end
         endcase
      end else if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Power-on reset is the only path out of the hard trips
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '0;
         st_ff.ctrl <= CTRL_RESET;
         st_ff.mode <= mode_run;
         st_ff.cause <= no_trip_code;
         st_ff.disp <= no_trip_code;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign trip_out = st_ff.mode == mode_trip;
   assign motor_enable = st_ff.mode == mode_run;
   assign run_source = st_ff.run_src_act;
   assign display_code = st_ff.disp;
   assign display_flash = st_ff.flash;
   assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
   assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_arready = !st_ff.rvalid;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rresp = st_ff.rresp;
   assign s_axi_rdata = st_ff.rdata;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_fault_trips_motor: assert property (
      det != '0 |=> trip_out && !motor_enable)
      else $error("fault did not trip");
   a_pause_no_trip: assert property (
      uv_low && !st_ff.ctrl[CTRL_UV_TRIP] && st_ff.latch == '0
      && det == '0 |=> !trip_out && !motor_enable)
      else $error("undervoltage pause wrong");
   a_uv_trip_mode: assert property (
      uv_low && st_ff.ctrl[CTRL_UV_TRIP] |=>
      trip_out && st_ff.latch[F_UV])
      else $error("undervoltage trip missing");
   a_warn_flash: assert property (
      display_flash |-> $past(checks.keypad_present))
      else $error("flash without keypad");
   a_code_hidden: assert property (
      !$past(checks.keypad_present) |-> display_code == no_trip_code)
      else $error("code shown without keypad");
   a_overload_hold: assert property (
      st_ff.latch[F_OL] && !$past(st_ff.latch[F_OL]) |->
      $past(st_ff.ol_cnt) == OL_LIM)
      else $error("overload tripped early");
   a_hard_sticky: assert property (
      (st_ff.latch & HARD_MASK) != '0 |=> trip_out)
      else $error("hard trip cleared");
   a_held_reset: assert property (
      trip_out && st_ff.rst_prev && rst_cond |=> trip_out)
      else $error("held reset cleared trip");
   a_clear_edge: assert property (
      $fell(trip_out) |-> $past(rst_edge) && $past(det) == '0)
      else $error("trip left without reset edge");
   a_src_change: assert property (
      cau_evt |=> trip_out ##1 run_source == $past(run_source, 2))
      else $error("setting change not tripped");
endmodule : fault_trip_supervisor
`default_nettype wire

// ---- verilog/fault_sup_pkg.sv ----
// Purpose: Shared constants and types for the motor fault trip supervisor.
// Assumes: AXI4-Lite register access, 32-bit data, 125 MHz clock.
// Notes: Summary of operation follows.
// Summary of operation
// - Any detected protective fault stops the motor and raises the trip output.
// - Checks always run; fault codes are shown only with the keypad attached.
// - Low DC bus pauses the motor without trip; it resumes on recovery.
// - With undervoltage trip mode selected, low DC bus latches a trip instead.
// - Load above warning level flashes the display and does not trip.
// - Load held above the overload level trips the motor.
// - Motor current above its limit raises an overcurrent trip.
// - DC bus above the overvoltage level raises an overvoltage trip.
// - Corrupt stored user settings raise a user setting fault.
// - Corrupt stored factory settings raise a factory setting fault.
// - A control processor malfunction raises a processor trip.
// - A rotor position sensor fault raises a sensor trip.
// - Speed above about 4500 rpm raises an overspeed trip.
// - Control section above about 105 degrees raises an overheat trip.
// - Changing the run source forces a trip; new value applies after reset.
// - Power removal and reapplication clears every trip.
// - Reset needs both inputs in direction modes, second input in reset modes.
// - A reset input held continuously has no further effect.
// - Overcurrent, sensor, processor and user setting trips clear only by power.
`default_nettype none
package fault_sup_pkg;
   localparam int ADDR_W = 4;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_CAUSE = 4'h8;
   localparam logic [3:0] ADDR_LATCH = 4'hC;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam int CTRL_UV_TRIP = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_RUN_SRC = 3;
   // Latch bit i reports fault code i+1
   localparam int F_UV = 0, F_OL = 1, F_OC = 2, F_OV = 3, F_UPR = 4;
   localparam int F_SPR = 5, F_SYS = 6, F_SEN = 7, F_OS = 8, F_OH = 9;
   localparam int F_CAU = 10, NFLT = 11;
   localparam logic [10:0] HARD_MASK = 11'h0D4;
   localparam int V_W = 10, CNT_W = 20;
   localparam logic [9:0] UV_LIM_100 = 10'h064;
   localparam logic [9:0] UV_LIM_200 = 10'h0C8;
   localparam logic [9:0] OV_LIM_100 = 10'h0C8;
   localparam logic [9:0] OV_LIM_200 = 10'h190;
   localparam logic [7:0] OLW_SMALL = 8'h64;
   localparam logic [7:0] OLW_BIG = 8'h50;
   localparam logic [7:0] OLT_SMALL = 8'h73;
   localparam logic [7:0] OLT_BIG = 8'h69;
   localparam logic [12:0] SPEED_LIM = 13'h1194;
   localparam logic [7:0] TEMP_LIM = 8'h69;
   typedef enum logic [1:0] {
      mode_run = 2'b00, mode_pause = 2'b01, mode_trip = 2'b10
   } mode_t;
   typedef enum logic [1:0] {
      in_fwd_rev = 2'b00, in_rev_fwd = 2'b01,
      in_fwd_rst = 2'b10, in_rev_rst = 2'b11
   } in_mode_t;
   typedef enum logic [3:0] {
      no_trip_code = 4'h0, undervoltage_trip_code = 4'h1,
      overload_trip_code = 4'h2, overcurrent_trip_code = 4'h3,
      overvoltage_trip_code = 4'h4, user_setting_fault_code = 4'h5,
      factory_setting_fault_code = 4'h6, processor_fault_code = 4'h7,
      position_sensor_fault_code = 4'h8, overspeed_trip_code = 4'h9,
      overheat_trip_code = 4'hA, setting_change_trip_code = 4'hB,
      undervoltage_pause_code = 4'hC
   } code_t;
   typedef struct packed {
      logic [V_W-1:0] dc_bus_v;
      logic [7:0] load_pct;
      logic [12:0] speed_rpm;
      logic [7:0] temp_c;
   } meas_t;
   typedef struct packed {
      logic overcurrent;
      logic user_param_bad;
      logic sys_param_bad;
      logic cpu_fault;
      logic sensor_fault;
      logic keypad_present;
   } check_t;
   typedef struct packed {
      mode_t mode;
      logic [NFLT-1:0] latch;
      code_t cause;
      code_t disp;
      logic flash;
      logic warn;
      logic [3:0] ctrl;
      logic run_src_act;
      logic [1:0] s1, s2, s3, filt;
      logic rst_prev;
      logic [CNT_W-1:0] ol_cnt;
      logic aw_got, w_got, wstrb0;
      logic [ADDR_W-1:0] awaddr;
      logic [3:0] wdata;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } state_t;
endpackage : fault_sup_pkg
`default_nettype wire

// ---- sim/ext_controller.sv ----
// Purpose: Machine controller model driving the two digital inputs.
// Assumes: Bench sets the input mode and a trip reset request level.
// Notes: wrong_pat drives the second input alone, whatever the mode.
`timescale 1ns/1ps
`default_nettype none
module ext_controller (
   input wire logic clk,
   input wire logic [1:0] in_mode,
   input wire logic rst_req,
   input wire logic wrong_pat,
   output logic first_digital_input,
   output logic second_digital_input
);
   // Direction modes need both inputs together, reset modes the second
   always @(posedge clk) begin
      first_digital_input <= rst_req & !in_mode[1] & !wrong_pat;
      second_digital_input <= rst_req;
   end
endmodule : ext_controller
`default_nettype wire

// ---- sim/motor_fault_trip_supervisor_tb_top.sv ----
// Purpose: Self-checking bench for the fault trip supervisor.
// Assumes: 100 V product, small unit, overload dwell shortened to 8.
// Notes: Ready and valid are looked at on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module motor_fault_trip_supervisor_tb_top;
   import fault_sup_pkg::*;
   logic clk = 1'h0;
   logic resetn = 1'h0;
   meas_t meas;
   check_t checks;
   logic fdi, sdi, trip_out, motor_enable, run_source, display_flash;
   logic [1:0] in_mode = 2'h0;
   logic rst_req = 1'h0;
   logic wrong_pat = 1'h0;
   code_t display_code;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   int err_count = 0;
   int samples_checked = 0;
   always #4 clk = ~clk;
   ext_controller ctl (.clk(clk), .in_mode(in_mode), .rst_req(rst_req),
      .wrong_pat(wrong_pat), .first_digital_input(fdi),
      .second_digital_input(sdi));
   fault_trip_supervisor #(.OL_HOLD(8)) dut (.clk(clk), .resetn(resetn),
      .meas(meas), .checks(checks), .first_digital_input(fdi),
      .second_digital_input(sdi), .trip_out(trip_out),
      .motor_enable(motor_enable), .run_source(run_source),
      .display_code(display_code), .display_flash(display_flash),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      logic ta, tw, tb;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(negedge clk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         @(posedge clk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
         n++;
      end while (!tb && n < 50);
      bready <= 1'h0;
      chk(tb, 1'h1);
      chk(bresp, RESP_OKAY);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e,
                     input logic [1:0] er);
      int n;
      logic ta, tr;
      logic [31:0] d;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(negedge clk);
         ta = arvalid & arready;
         tr = rvalid;
         d = rdata;
         chk(tr ? rresp : er, er);
         @(posedge clk);
         if (ta) arvalid <= 1'h0;
         n++;
      end while (!tr && n < 50);
      rready <= 1'h0;
      chk(tr, 1'h1);
      if (er == RESP_OKAY) chk(d, e);
   endtask : rd
   task automatic wait_sig(input bit me, input logic v);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while ((me ? motor_enable : trip_out) !== v && n < 40);
      chk(me ? motor_enable : trip_out, v);
      // Hand back on a rising edge so the next stimulus lands there
      @(posedge clk);
   endtask : wait_sig
   task automatic nominal();
      meas <= '{10'h096, 8'h32, 13'h03E8, 8'h28};
      checks <= 6'h01;
   endtask : nominal
   task automatic pulse(input logic w);
      @(posedge clk);
      wrong_pat <= w;
      rst_req <= 1'h1;
      cyc(8);
      rst_req <= 1'h0;
      wrong_pat <= 1'h0;
      cyc(8);
   endtask : pulse
   task automatic power();
      @(posedge clk);
      resetn <= 1'h0;
      in_mode <= 2'h0;
      cyc(2);
      resetn <= 1'h1;
      cyc(1);
   endtask : power
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_uv();
      rd(ADDR_STATUS, 32'h8, RESP_OKAY);
      rd(4'h2, 32'h0, RESP_SLVERR);
      meas.dc_bus_v <= 10'h063;
      wait_sig(1'h1, 1'h0);
      chk(trip_out, 1'h0);
      chk(display_code, undervoltage_pause_code);
      meas.dc_bus_v <= 10'h064;
      wait_sig(1'h1, 1'h1);
      wr(ADDR_CTRL, 32'h1);
      meas.dc_bus_v <= 10'h063;
      wait_sig(1'h0, 1'h1);
      chk(motor_enable, 1'h0);
      rd(ADDR_CAUSE, 32'h1, RESP_OKAY);
      nominal();
      pulse(1'h0);
      wait_sig(1'h0, 1'h0);
      wr(ADDR_CTRL, 32'h0);
      $display("done: undervoltage");
   endtask : t_uv
   task automatic t_soft();
      code_t cd[4];
      cd = '{overvoltage_trip_code, overspeed_trip_code,
             overheat_trip_code, factory_setting_fault_code};
      for (int k = 0; k < 4; k++) begin
         in_mode <= 2'(k);
         wr(ADDR_CTRL, {29'h0, 2'(k), 1'h0});
         case (k)
            0: meas.dc_bus_v <= 10'h0C9;
            1: meas.speed_rpm <= 13'h1195;
            2: meas.temp_c <= 8'h6A;
            default: checks.sys_param_bad <= 1'h1;
         endcase
         wait_sig(1'h0, 1'h1);
         chk(display_code, cd[k]);
         rd(ADDR_CAUSE, {28'h0, cd[k]}, RESP_OKAY);
         nominal();
         if (k < 2) begin
            pulse(1'h1);
            chk(trip_out, 1'h1);
         end
         pulse(1'h0);
         wait_sig(1'h0, 1'h0);
      end
      @(posedge clk);
      rst_req <= 1'h1;
      cyc(8);
      meas.dc_bus_v <= 10'h0C9;
      wait_sig(1'h0, 1'h1);
      nominal();
      cyc(12);
      chk(trip_out, 1'h1);
      rst_req <= 1'h0;
      cyc(8);
      pulse(1'h0);
      wait_sig(1'h0, 1'h0);
      $display("done: resettable trips");
   endtask : t_soft
   task automatic t_hard();
      int hb[4];
      logic [3:0] hc[4];
      hb = '{5, 4, 2, 1};
      hc = '{4'h3, 4'h5, 4'h7, 4'h8};
      for (int j = 0; j < 4; j++) begin
         checks[hb[j]] <= 1'h1;
         wait_sig(1'h0, 1'h1);
         rd(ADDR_CAUSE, {28'h0, hc[j]}, RESP_OKAY);
         nominal();
         pulse(1'h0);
         chk(trip_out, 1'h1);
         power();
         wait_sig(1'h0, 1'h0);
      end
      $display("done: power-only trips");
   endtask : t_hard
   task automatic t_load();
      meas.load_pct <= 8'h65;
      cyc(20);
      chk(display_flash, 1'h1);
      chk(trip_out, 1'h0);
      rd(ADDR_STATUS, 32'hC, RESP_OKAY);
      meas.load_pct <= 8'h73;
      cyc(30);
      chk(trip_out, 1'h0);
      meas.load_pct <= 8'h74;
      wait_sig(1'h0, 1'h1);
      rd(ADDR_CAUSE, 32'h2, RESP_OKAY);
      checks.keypad_present <= 1'h0;
      cyc(3);
      chk(display_code, no_trip_code);
      chk(display_flash, 1'h0);
      nominal();
      pulse(1'h0);
      wait_sig(1'h0, 1'h0);
      $display("done: overload");
   endtask : t_load
   task automatic t_set();
      wr(ADDR_CTRL, 32'h8);
      wait_sig(1'h0, 1'h1);
      chk(run_source, 1'h0);
      rd(ADDR_CAUSE, 32'hB, RESP_OKAY);
      pulse(1'h0);
      wait_sig(1'h0, 1'h0);
      chk(run_source, 1'h1);
      $display("done: setting change");
   endtask : t_set
   initial begin
      meas = '{10'h096, 8'h32, 13'h03E8, 8'h28};
      checks = 6'h01;
      cyc(16);
      resetn <= 1'h1;
      cyc(1);
      t_uv();
      t_soft();
      t_hard();
      t_load();
      t_set();
      test_done();
   end
   // Whole run takes several hundred cycles; this limit of 50000 cycles is far beyond it
   initial begin
      #400000;
      err_count++;
      test_done();
   end
endmodule : motor_fault_trip_supervisor_tb_top
`default_nettype wire
